//--- bench/dgp_bb_model.sv
// Baseband side model: drives the pins the device leaves as inputs.
// Assumes device outputs are fed back onto the shared pin wires.
`timescale 1ns/10ps

module dgp_bb_model (
  input wire core_clk,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  output wire [15:0] pin_in
);
  logic [15:0] drv = 16'h0000;

  // Device wins where it drives, so the model never fights it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);

  // Step pulse held at least two clocks, then a low gap
  task pulse(input int idx, input int hi);
    int n;
    n = (hi < 2) ? 2 : hi;
    @(negedge core_clk) drv[idx] = 1'b1;
    repeat (n) @(negedge core_clk);
    drv[idx] = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
endmodule

//--- bench/dgp_function_map_sva.sv
// Checker for the pin function map: pair routing, manual mode, gain limits.
// Assumes a bind onto the top module; sees only its ports.
`timescale 1ns/10ps
`include "dgp_map.vh"

module dgp_function_map_chk (
  input wire core_clk,
  input wire rst,
  input wire [`DGP_PINS-1:0] pin_out,
  input wire [`DGP_PINS-1:0] pin_oe,
  input wire [`DGP_PAIRS*`DGP_SRC_W-1:0] pair_source,
  input wire [`DGP_PINS-1:0] manual_out_level,
  input wire [`DGP_PINS-1:0] manual_out_readback,
  input wire stream_debug_en,
  input wire [3:0] stream_effective,
  input wire [1:0] gain_pin_mode,
  input wire [1:0] gain_load,
  input wire [`DGP_GAIN_W-1:0] gain_index_1,
  input wire [`DGP_GAIN_W-1:0] gain_max_1,
  input wire [1:0] pa_ramp_up_trig,
  input wire monitor_mode,
  input wire wake_condition
);
  // One domain: shared clock and reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Legal groups drive, illegal pairs stay inputs
  manual_drive_a: assert property (
    pair_source[17:15] == 3'h4 |=> pin_oe[11:10] == 2'h3 &&
    pin_out[11:10] == $past(manual_out_level[11:10])) else $error("manual pins wrong");
  manual_read_a: assert property (
    pair_source[17:15] == 3'h4 |=>
    manual_out_readback[11:10] == $past(manual_out_level[11:10])) else $error("readback wrong");
  refclk_low_a: assert property (
    pair_source[2:0] == 3'h6 |=> pin_oe[1:0] == 2'h0) else $error("refclk on low pair");
  status_high_a: assert property (
    pair_source[23:21] == 3'h1 |=> pin_oe[15:14] == 2'h0) else $error("status on high pair");
  debug_low_a: assert property (
    pair_source[8:6] == 3'h2 |=> pin_oe[5:4] == 2'h0) else $error("debug on wrong pair");
  debug_show_a: assert property (
    pair_source[5:3] == 3'h2 && stream_debug_en |=>
    pin_out[3:2] == $past(stream_effective[3:2])) else $error("debug pins wrong");
  wake_out_a: assert property (
    pair_source[17:15] == 3'h5 |=>
    (pin_out[11:10] != 2'h0) == $past(monitor_mode && wake_condition)) else $error("wake wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Gain index and trigger behaviour
  gain_hold_a: assert property (
    !gain_pin_mode[0] && !gain_load[0] |=> $stable(gain_index_1)) else $error("gain moved");
  gain_ceiling_a: assert property (
    gain_index_1 == gain_max_1 && !gain_load[0] && $stable(gain_max_1) |=>
    gain_index_1 <= gain_max_1) else $error("gain above max");
  trig_pulse_a: assert property (
    pa_ramp_up_trig[0] |=> !pa_ramp_up_trig[0]) else $error("trigger too long");
endmodule

bind dgp_function_map dgp_function_map_chk u_chk (.core_clk, .rst, .pin_out, .pin_oe,
  .pair_source, .manual_out_level, .manual_out_readback, .stream_debug_en, .stream_effective,
  .gain_pin_mode, .gain_load, .gain_index_1, .gain_max_1, .pa_ramp_up_trig, .monitor_mode,
  .wake_condition);

//--- bench/dgp_function_map_tb_top.sv
// Bench for the pin function map: gain, ramp, save, hop and pin outputs.
// Assumes the baseband model resolves the pins and the checker is bound.
`timescale 1ns/10ps

module dgp_function_map_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire [15:0] pin_in, pin_out, pin_oe, manual_out_readback, manual_in_level;
  wire [7:0] gain_index_1, gain_index_2;
  wire [1:0] pa_ramp_up_trig, pa_ramp_down_trig, hop_table_index, gain_table_index, atten_index;
  wire chan1_save_enable, chan2_save_enable, monitor_system_save_enable, hop_control;
  wire [9:0] in_feat = {chan1_save_enable, chan2_save_enable, monitor_system_save_enable,
    hop_control, hop_table_index, gain_table_index, atten_index};
  // Defaults also serve later tests
  logic [1:0] gain_pin_mode = 2'h3, gain_load = 2'h0, pa_ramp_en = 2'h3, status_group = 2'h0;
  logic [1:0] ovl_chan_sel = 2'h1, gain_change_flag = 2'h2, tx_ref_lvds = 2'h3;
  logic [1:0] apd_over = 2'h1, apd_under = 2'h2, hb_over = 2'h2, hb_under = 2'h1;
  logic [1:0] pwr_over = 2'h1, pwr_under = 2'h2;
  logic [3:0] gain_inc_sel_1 = 4'hF, gain_dec_sel_1 = 4'h0, gain_inc_sel_2 = 4'h7;
  logic [3:0] gain_dec_sel_2 = 4'h8, pa_sel_1 = 4'h9, pa_sel_2 = 4'h9, stream_effective = 4'h9;
  logic [3:0] chan1_save_sel = 4'h1, chan2_save_sel = 4'h2, sys_save_sel = 4'h3;
  logic [3:0] hop_ctl_sel = 4'h4, hop_tbl_sel = 4'h5, gain_tbl_sel = 4'hA, atten_sel = 4'hF;
  logic [7:0] gain_load_value = 8'hC4, gain_min_1 = 8'hC3, gain_max_1 = 8'hC6;
  logic [7:0] gain_min_2 = 8'hC3, gain_max_2 = 8'hFF, pa_rise_delay = 8'h00;
  logic [7:0] pa_fall_delay = 8'h03;
  logic [11:0] main_ctrl = 12'h100, rx_ctrl = 12'h200, tx_ctrl = 12'h300;
  logic [2:0] save_en = 3'h0;
  logic [23:0] pair_source = 24'h000000;
  logic [15:0] manual_out_level = 16'h0C00;
  logic pa_fall_delay_en = 1'b0, hop_en = 1'b0, agc_chan_sel = 1'b1, stream_debug_en = 1'b1;
  logic ovl_mode = 1'b0, monitor_mode = 1'b0, wake_condition = 1'b0, pv;
  int err_total = 0, n_compared = 0, cyc = 0, ra, fa, rb, fb, tg;
  logic [1:0] sx [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
  logic [5:0] ovx [6] = '{6'h25, 6'h1A, 6'h19, 6'h15, 6'h2A, 6'h29};

  dgp_function_map #(.DLY_W(8), .REF_DIV(2)) uut (.core_clk, .rst, .pin_in, .pin_out, .pin_oe,
    .gain_pin_mode, .gain_inc_sel_1, .gain_dec_sel_1, .gain_inc_sel_2, .gain_dec_sel_2,
    .gain_load, .gain_load_value, .gain_min_1, .gain_max_1, .gain_min_2, .gain_max_2,
    .gain_index_1, .gain_index_2, .pa_ramp_en, .pa_sel_1, .pa_sel_2, .pa_rise_delay,
    .pa_fall_delay, .pa_fall_delay_en, .pa_ramp_up_trig, .pa_ramp_down_trig, .save_en,
    .chan1_save_sel, .chan2_save_sel, .sys_save_sel, .chan1_save_enable, .chan2_save_enable,
    .monitor_system_save_enable, .hop_en, .hop_ctl_sel, .hop_tbl_sel, .gain_tbl_sel,
    .atten_sel, .hop_control, .hop_table_index, .gain_table_index, .atten_index,
    .pair_source, .status_group, .agc_chan_sel, .main_ctrl, .rx_ctrl, .tx_ctrl,
    .gain_change_flag, .stream_debug_en, .stream_effective, .ovl_mode, .ovl_chan_sel,
    .apd_over, .apd_under, .hb_over, .hb_under, .pwr_over, .pwr_under, .manual_out_level,
    .manual_out_readback, .manual_in_level, .monitor_mode, .wake_condition, .tx_ref_lvds);
  dgp_bb_model bb (.core_clk, .pin_out, .pin_oe, .pin_in);

  ////////////////////////////////////////////////////////////////////////////
  // Clock, comparison, verdict and hang guard
  initial forever #20 core_clk = ~core_clk;
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Run needs a few hundred cycles; beyond means a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      summarize();
    end
  end
  // Ramp pin edge, cycles until trigger
  task pa_lat(input logic lvl, output int n);
    @(negedge core_clk) bb.drv[9] = lvl;
    n = 0;
    do @(negedge core_clk) n++;
    while ((lvl ? pa_ramp_up_trig[0] : pa_ramp_down_trig[0]) !== 1'b1 && n < 400);
    chk("pa_both", lvl ? pa_ramp_up_trig : pa_ramp_down_trig, 2'h3);
    repeat (4) @(negedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    gain_load = 2'h1;
    @(negedge core_clk) gain_load = 2'h0;
    repeat (2) @(negedge core_clk);
    bb.pulse(15, 10);
    chk("gain1_long", gain_index_1, 8'hC5);
    repeat (3) bb.pulse(0, 2);
    chk("gain1_floor", gain_index_1, 8'hC3);
    repeat (4) bb.pulse(15, 2);
    chk("gain1_ceil", gain_index_1, 8'hC6);
    bb.pulse(7, 2);
    chk("gain2_ceil", gain_index_2, 8'hFF);
    bb.pulse(8, 2);
    chk("gain2_down", gain_index_2, 8'hFE);
    gain_pin_mode = 2'h0;
    bb.pulse(15, 2);
    chk("gain1_mode", gain_index_1, 8'hC6);
    $display("test gain done");
    pa_lat(1'b1, ra);
    pa_lat(1'b0, fa);
    pa_rise_delay = 8'h05;
    pa_fall_delay_en = 1'b1;
    pa_lat(1'b1, rb);
    pa_lat(1'b0, fb);
    chk("pa_rise_dly", rb - ra, 5);
    chk("pa_fall_dly", fb - fa, 3);
    $display("test ramp done");
    save_en = 3'h7;
    hop_en = 1'b1;
    bb.drv = 16'h883A;
    repeat (6) @(negedge core_clk);
    chk("save_hop", in_feat, 10'h2D9);
    chk("man_in", manual_in_level, 16'h883A);
    $display("test save_hop done");
    pair_source = 24'h3A16D3;
    repeat (3) @(negedge core_clk);
    chk("oe_a", pin_oe, 16'h3FFF);
    chk("debug", pin_out[3:2], 2'h2);
    chk("man_out", pin_out[11:10], 2'h3);
    manual_out_level = 16'h0400;
    repeat (2) @(negedge core_clk);
    chk("man_rb", manual_out_readback, 16'h0400);
    for (int g = 0; g < 4; g++) begin
      status_group = 2'(g);
      repeat (2) @(negedge core_clk);
      chk("status", pin_out[9:8], sx[g]);
    end
    for (int i = 0; i < 6; i++) begin
      ovl_mode = (i >= 3);
      ovl_chan_sel = 2'(i % 3 + 1);
      repeat (2) @(negedge core_clk);
      chk("ovl", {pin_out[7:4], pin_out[1:0]}, ovx[i]);
    end
    tg = 0;
    @(negedge core_clk) pv = pin_out[12];
    repeat (16) begin
      @(negedge core_clk) tg += (pin_out[12] !== pv);
      pv = pin_out[12];
    end
    chk("ref_rate", tg, 8);
    chk("ref_lvds", pin_out[13], !pin_out[12]);
    @(negedge core_clk) pair_source = 24'hDA96D3;
    for (int w = 0; w < 3; w++) begin
      {stream_debug_en, monitor_mode, wake_condition} = (w == 0) ? 3'h3 : 3'(w);
      repeat (2) @(negedge core_clk);
      chk("wake", pin_out[11:10] != 2'h0, w == 0);
    end
    chk("oe_b", pin_oe, 16'hFFFF);
    chk("dbg_off", pin_out[3:2], 2'h0);
    chk("ref2", pin_out[15:14], {!pin_out[12], pin_out[12]});
    pair_source = 24'h840086;
    repeat (2) @(negedge core_clk);
    chk("oe_refused", pin_oe, 16'h0000);
    $display("test outputs done");
    summarize();
  end
endmodule

//--- rtl/dgp_function_map.v
// Digital general-purpose pin function map: input features (gain stepping,
// amplifier ramp triggers, power-save and hop controls) and output features
// (status mux, stream debug, overload, manual, wake-up, reference clock).
// Assumes one core clock, synchronous reset, pins asynchronous to it.
//
// How it works
// RULE1 - Pin pulses step channel gain index
// RULE2 - Partner holds step pulses two clocks
// RULE3 - Step pins selectable from pins 0-15
// RULE4 - Gain index saturates at programmed limits
// RULE5 - Delayed rising edge triggers ramp up
// RULE6 - Optionally delayed falling edge triggers ramp down
// RULE7 - Pins drive channel and system save enables
// RULE8 - Pins drive hop control and indices
// RULE9 - Status mux only on pins 0-11
// RULE10 - AGC flag and index routable to pins
// RULE11 - Stream debug shows enables on pins 0-3
// RULE12 - Peak mode reports analog and halfband ranges
// RULE13 - Power mode reports analog and power ranges
// RULE14 - Overload pins per receiver or both
// RULE15 - Manual output drives and reads back level
// RULE16 - Manual input level readable by software
// RULE17 - Wake-up asserted in monitor mode on condition
// RULE18 - Reference clocks on pins 12-13, 14-15
// RULE19 - Output feature forces pin to output
// RULE20 - Pin pairs share one source group
// RULE21 - Partner assigns one function per pin
// RULE22 - Inputs synchronised, one action per edge
// RULE23 - Gain steps only in pin control mode
`timescale 1ns/10ps
`include "dgp_map.vh"

module dgp_function_map #(
  parameter DLY_W = 8,
  parameter REF_DIV = 2
) (
  input wire core_clk,
  input wire rst,
  input wire [`DGP_PINS-1:0] pin_in,
  output wire [`DGP_PINS-1:0] pin_out,
  output wire [`DGP_PINS-1:0] pin_oe,
  input wire [1:0] gain_pin_mode,
  input wire [`DGP_SEL_W-1:0] gain_inc_sel_1,
  input wire [`DGP_SEL_W-1:0] gain_dec_sel_1,
  input wire [`DGP_SEL_W-1:0] gain_inc_sel_2,
  input wire [`DGP_SEL_W-1:0] gain_dec_sel_2,
  input wire [1:0] gain_load,
  input wire [`DGP_GAIN_W-1:0] gain_load_value,
  input wire [`DGP_GAIN_W-1:0] gain_min_1,
  input wire [`DGP_GAIN_W-1:0] gain_max_1,
  input wire [`DGP_GAIN_W-1:0] gain_min_2,
  input wire [`DGP_GAIN_W-1:0] gain_max_2,
  output wire [`DGP_GAIN_W-1:0] gain_index_1,
  output wire [`DGP_GAIN_W-1:0] gain_index_2,
  input wire [1:0] pa_ramp_en,
  input wire [`DGP_SEL_W-1:0] pa_sel_1,
  input wire [`DGP_SEL_W-1:0] pa_sel_2,
  input wire [DLY_W-1:0] pa_rise_delay,
  input wire [DLY_W-1:0] pa_fall_delay,
  input wire pa_fall_delay_en,
  output wire [1:0] pa_ramp_up_trig,
  output wire [1:0] pa_ramp_down_trig,
  input wire [2:0] save_en,
  input wire [`DGP_SEL_W-1:0] chan1_save_sel,
  input wire [`DGP_SEL_W-1:0] chan2_save_sel,
  input wire [`DGP_SEL_W-1:0] sys_save_sel,
  output wire chan1_save_enable,
  output wire chan2_save_enable,
  output wire monitor_system_save_enable,
  input wire hop_en,
  input wire [`DGP_SEL_W-1:0] hop_ctl_sel,
  input wire [`DGP_SEL_W-1:0] hop_tbl_sel,
  input wire [`DGP_SEL_W-1:0] gain_tbl_sel,
  input wire [`DGP_SEL_W-1:0] atten_sel,
  output wire hop_control,
  output wire [1:0] hop_table_index,
  output wire [1:0] gain_table_index,
  output wire [1:0] atten_index,
  input wire [`DGP_PAIRS*`DGP_SRC_W-1:0] pair_source,
  input wire [1:0] status_group,
  input wire agc_chan_sel,
  input wire [`DGP_STAT_W-1:0] main_ctrl,
  input wire [`DGP_STAT_W-1:0] rx_ctrl,
  input wire [`DGP_STAT_W-1:0] tx_ctrl,
  input wire [1:0] gain_change_flag,
  input wire stream_debug_en,
  input wire [3:0] stream_effective,
  input wire ovl_mode,
  input wire [1:0] ovl_chan_sel,
  input wire [1:0] apd_over,
  input wire [1:0] apd_under,
  input wire [1:0] hb_over,
  input wire [1:0] hb_under,
  input wire [1:0] pwr_over,
  input wire [1:0] pwr_under,
  input wire [`DGP_PINS-1:0] manual_out_level,
  output wire [`DGP_PINS-1:0] manual_out_readback,
  output wire [`DGP_PINS-1:0] manual_in_level,
  input wire monitor_mode,
  input wire wake_condition,
  input wire [1:0] tx_ref_lvds
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // One pin out of the synchronised set
  function pick1;
    input [`DGP_PINS-1:0] vec;
    input [`DGP_SEL_W-1:0] sel;
    begin
      pick1 = vec[sel];
    end
  endfunction

  // Two consecutive pins, wrapping past the last one
  function [1:0] pick2;
    input [`DGP_PINS-1:0] vec;
    input [`DGP_SEL_W-1:0] sel;
    reg [`DGP_SEL_W-1:0] nxt;
    begin
      nxt = sel + {{(`DGP_SEL_W-1){1'b0}}, 1'b1};
      pick2 = {vec[nxt], vec[sel]};
    end
  endfunction

  // Whether a source group may sit on a given pair
  function src_ok;
    input [`DGP_SRC_W-1:0] src;
    input [2:0] pair;
    begin
      case (src)
        `DGP_SRC_STATUS,
        `DGP_SRC_OVERLOAD,
        `DGP_SRC_MANUAL,
        `DGP_SRC_WAKEUP: src_ok = (pair <= `DGP_LOW_PAIR_MAX); // RULE9
        `DGP_SRC_DEBUG: src_ok = (pair <= `DGP_DEBUG_PAIR_MAX); // RULE11
        `DGP_SRC_REFCLK: src_ok = (pair == `DGP_REFCLK_PAIR_1) ||
                                  (pair == `DGP_REFCLK_PAIR_2); // RULE18
        default: src_ok = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge pulses

  wire [`DGP_PINS-1:0] pin_level;
  wire [`DGP_PINS-1:0] pin_rise;
  wire [`DGP_PINS-1:0] pin_fall;

  // Pulses shorter than two clocks may be missed by the sampler
  dgp_pin_sync #(
    .WIDTH(`DGP_PINS)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_async(pin_in),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  ); // RULE22 RULE2

  ////////////////////////////////////////////////////////////////////////
  // Receive gain stepping

  wire inc_1;
  wire dec_1;
  wire inc_2;
  wire dec_2;

  // Any of the sixteen pins; ignored unless the channel is in pin mode
  assign inc_1 = gain_pin_mode[0] & pick1(pin_rise, gain_inc_sel_1); // RULE23 RULE3
  assign dec_1 = gain_pin_mode[0] & pick1(pin_rise, gain_dec_sel_1); // RULE23 RULE3
  assign inc_2 = gain_pin_mode[1] & pick1(pin_rise, gain_inc_sel_2); // RULE23 RULE3
  assign dec_2 = gain_pin_mode[1] & pick1(pin_rise, gain_dec_sel_2); // RULE23 RULE3

  dgp_gain_stepper u_gain_1 (
    .core_clk(core_clk),
    .rst(rst),
    .step_up(inc_1),
    .step_down(dec_1),
    .load(gain_load[0]),
    .load_value(gain_load_value),
    .index_min(gain_min_1),
    .index_max(gain_max_1),
    .index(gain_index_1)
  ); // RULE1

  dgp_gain_stepper u_gain_2 (
    .core_clk(core_clk),
    .rst(rst),
    .step_up(inc_2),
    .step_down(dec_2),
    .load(gain_load[1]),
    .load_value(gain_load_value),
    .index_min(gain_min_2),
    .index_max(gain_max_2),
    .index(gain_index_2)
  ); // RULE1

  ////////////////////////////////////////////////////////////////////////
  // Amplifier ramp triggers

  reg [DLY_W-1:0] up_cnt_reg [0:1];
  reg [DLY_W-1:0] dn_cnt_reg [0:1];
  reg [1:0] up_pend_reg;
  reg [1:0] dn_pend_reg;
  reg [1:0] up_trig_reg;
  reg [1:0] dn_trig_reg;
  wire [1:0] pa_rise;
  wire [1:0] pa_fall;
  wire [DLY_W-1:0] fall_delay;
  integer ch;

  assign pa_rise[0] = pa_ramp_en[0] & pick1(pin_rise, pa_sel_1);
  assign pa_rise[1] = pa_ramp_en[1] & pick1(pin_rise, pa_sel_2);
  assign pa_fall[0] = pa_ramp_en[0] & pick1(pin_fall, pa_sel_1);
  assign pa_fall[1] = pa_ramp_en[1] & pick1(pin_fall, pa_sel_2);
  // Fall delay is optional; zero puts the trigger two cycles after the edge pulse
  assign fall_delay = pa_fall_delay_en ? pa_fall_delay : {DLY_W{1'b0}};

  // A fresh edge restarts its own pending delay rather than queueing
  always @(posedge core_clk) begin
    if (rst) begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        up_cnt_reg[ch] <= {DLY_W{1'b0}};
        dn_cnt_reg[ch] <= {DLY_W{1'b0}};
      end
      up_pend_reg <= 2'h0;
      dn_pend_reg <= 2'h0;
      up_trig_reg <= 2'h0;
      dn_trig_reg <= 2'h0;
    end else begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        up_trig_reg[ch] <= 1'b0;
        dn_trig_reg[ch] <= 1'b0;
        if (pa_rise[ch]) begin
          up_pend_reg[ch] <= 1'b1;
          up_cnt_reg[ch] <= pa_rise_delay; // RULE5
        end else if (up_pend_reg[ch]) begin
          if (up_cnt_reg[ch] == {DLY_W{1'b0}}) begin
            up_pend_reg[ch] <= 1'b0;
            up_trig_reg[ch] <= 1'b1; // RULE5
          end else begin
            up_cnt_reg[ch] <= up_cnt_reg[ch] - {{(DLY_W-1){1'b0}}, 1'b1};
          end
        end
        if (pa_fall[ch]) begin
          dn_pend_reg[ch] <= 1'b1;
          dn_cnt_reg[ch] <= fall_delay; // RULE6
        end else if (dn_pend_reg[ch]) begin
          if (dn_cnt_reg[ch] == {DLY_W{1'b0}}) begin
            dn_pend_reg[ch] <= 1'b0;
            dn_trig_reg[ch] <= 1'b1; // RULE6
          end else begin
            dn_cnt_reg[ch] <= dn_cnt_reg[ch] - {{(DLY_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

  assign pa_ramp_up_trig = up_trig_reg;
  assign pa_ramp_down_trig = dn_trig_reg;

  ////////////////////////////////////////////////////////////////////////
  // Power-save and hopping level inputs

  reg [2:0] save_reg;
  reg hop_ctl_reg;
  reg [1:0] hop_tbl_reg;
  reg [1:0] gain_tbl_reg;
  reg [1:0] atten_reg;

  // Levels follow the synchronised pins while each function is enabled
  always @(posedge core_clk) begin
    if (rst) begin
      save_reg <= 3'h0;
      hop_ctl_reg <= 1'b0;
      hop_tbl_reg <= 2'h0;
      gain_tbl_reg <= 2'h0;
      atten_reg <= 2'h0;
    end else begin
      save_reg[0] <= save_en[0] & pick1(pin_level, chan1_save_sel); // RULE7
      save_reg[1] <= save_en[1] & pick1(pin_level, chan2_save_sel); // RULE7
      save_reg[2] <= save_en[2] & pick1(pin_level, sys_save_sel); // RULE7
      hop_ctl_reg <= hop_en & pick1(pin_level, hop_ctl_sel); // RULE8
      hop_tbl_reg <= hop_en ? pick2(pin_level, hop_tbl_sel) : 2'h0; // RULE8
      gain_tbl_reg <= hop_en ? pick2(pin_level, gain_tbl_sel) : 2'h0; // RULE8
      atten_reg <= hop_en ? pick2(pin_level, atten_sel) : 2'h0; // RULE8
    end
  end

  assign chan1_save_enable = save_reg[0];
  assign chan2_save_enable = save_reg[1];
  assign monitor_system_save_enable = save_reg[2];
  assign hop_control = hop_ctl_reg;
  assign hop_table_index = hop_tbl_reg;
  assign gain_table_index = gain_tbl_reg;
  assign atten_index = atten_reg;

  ////////////////////////////////////////////////////////////////////////
  // Output sources

  reg [`DGP_STAT_W-1:0] stat_word;
  wire [`DGP_GAIN_W-1:0] agc_index;
  wire [3:0] ovl_rx1;
  wire [3:0] ovl_rx2;
  wire wake;

  assign agc_index = agc_chan_sel ? gain_index_2 : gain_index_1;

  // Selected group of internal control signals
  always @* begin
    case (status_group)
      `DGP_GRP_MAIN: stat_word = main_ctrl; // RULE9
      `DGP_GRP_RX: stat_word = rx_ctrl; // RULE9
      `DGP_GRP_TX: stat_word = tx_ctrl; // RULE9
      default: stat_word = {3'h0, gain_change_flag[agc_chan_sel], agc_index}; // RULE10
    endcase
  end

  // Four range flags per receiver, picked by detector mode
  assign ovl_rx1 = ovl_mode ?
    {pwr_under[0], pwr_over[0], apd_under[0], apd_over[0]} : // RULE13
    {hb_under[0], hb_over[0], apd_under[0], apd_over[0]}; // RULE12
  assign ovl_rx2 = ovl_mode ?
    {pwr_under[1], pwr_over[1], apd_under[1], apd_over[1]} : // RULE13
    {hb_under[1], hb_over[1], apd_under[1], apd_over[1]}; // RULE12

  assign wake = monitor_mode & wake_condition; // RULE17

  ////////////////////////////////////////////////////////////////////////
  // Reference clock divider

  reg [15:0] div_cnt_reg;
  reg ref_clk_reg;

  // Half period of REF_DIV core clocks
  always @(posedge core_clk) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      ref_clk_reg <= 1'b0;
    end else if (div_cnt_reg == REF_DIV[15:0] - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
      ref_clk_reg <= ~ref_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin output mux

  reg [`DGP_PINS-1:0] out_next;
  reg [`DGP_PINS-1:0] oe_next;
  reg [`DGP_PINS-1:0] man_next;
  reg [`DGP_SRC_W-1:0] src;
  reg [2:0] pair;
  reg [3:0] pin_idx;
  reg use_rx2;
  integer k;

  // Both pins of a pair follow the pair's one source code
  always @* begin
    out_next = {`DGP_PINS{1'b0}};
    oe_next = {`DGP_PINS{1'b0}};
    man_next = {`DGP_PINS{1'b0}};
    src = `DGP_SRC_NONE;
    pair = 3'h0;
    pin_idx = 4'h0;
    use_rx2 = 1'b0;
    for (k = 0; k < `DGP_PINS; k = k + 1) begin
      pin_idx = k[3:0];
      pair = pin_idx[3:1];
      src = pair_source[pair*`DGP_SRC_W +: `DGP_SRC_W]; // RULE20
      use_rx2 = (ovl_chan_sel == `DGP_OVL_BOTH) ? pin_idx[2] :
                (ovl_chan_sel == `DGP_OVL_RX2); // RULE14
      if (src_ok(src, pair)) begin
        oe_next[k] = 1'b1; // RULE19
        case (src)
          `DGP_SRC_STATUS: out_next[k] = stat_word[pin_idx]; // RULE9
          `DGP_SRC_DEBUG: out_next[k] = stream_debug_en &
                                        stream_effective[pin_idx[1:0]]; // RULE11
          `DGP_SRC_OVERLOAD: out_next[k] = use_rx2 ? ovl_rx2[pin_idx[1:0]] :
                                           ovl_rx1[pin_idx[1:0]]; // RULE14
          `DGP_SRC_MANUAL: begin
            out_next[k] = manual_out_level[k]; // RULE15
            man_next[k] = 1'b1;
          end
          `DGP_SRC_WAKEUP: out_next[k] = wake; // RULE17
          `DGP_SRC_REFCLK: out_next[k] = (pin_idx[0] &
                                          tx_ref_lvds[pin_idx[1]]) ^
                                         ref_clk_reg; // RULE18
          default: out_next[k] = 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pin drive and software readouts

  reg [`DGP_PINS-1:0] out_reg;
  reg [`DGP_PINS-1:0] oe_reg;
  reg [`DGP_PINS-1:0] readback_reg;

  // Pins come up as inputs; misassigned groups stay inputs too
  always @(posedge core_clk) begin
    if (rst) begin
      out_reg <= {`DGP_PINS{1'b0}};
      oe_reg <= {`DGP_PINS{1'b0}};
      readback_reg <= {`DGP_PINS{1'b0}};
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next; // RULE19
      readback_reg <= out_next & man_next; // RULE15
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign manual_out_readback = readback_reg;
  // Sampled level of every pin, meaningful for manual inputs
  assign manual_in_level = pin_level; // RULE16

endmodule

//--- rtl/dgp_gain_stepper.v
// One receive channel's gain index, stepped by single-cycle pulses.
// Assumes pulses already qualified by the caller; min must not exceed max.
`timescale 1ns/10ps
`include "dgp_map.vh"

module dgp_gain_stepper (
  input wire core_clk,
  input wire rst,
  input wire step_up,
  input wire step_down,
  input wire load,
  input wire [`DGP_GAIN_W-1:0] load_value,
  input wire [`DGP_GAIN_W-1:0] index_min,
  input wire [`DGP_GAIN_W-1:0] index_max,
  output wire [`DGP_GAIN_W-1:0] index
);

  reg [`DGP_GAIN_W-1:0] index_reg;
  reg [`DGP_GAIN_W-1:0] index_next;

  ////////////////////////////////////////////////////////////////////////
  // Load wins; opposing steps in one cycle cancel out
  always @* begin
    index_next = index_reg;
    if (load) begin
      index_next = load_value;
    end else if (step_up && !step_down) begin
      if (index_reg < index_max) begin // RULE4
        index_next = index_reg + {{(`DGP_GAIN_W-1){1'b0}}, 1'b1}; // RULE1
      end
    end else if (step_down && !step_up) begin
      if (index_reg > index_min) begin // RULE4
        index_next = index_reg - {{(`DGP_GAIN_W-1){1'b0}}, 1'b1}; // RULE1
      end
    end
  end

  // Index register
  always @(posedge core_clk) begin
    if (rst) begin
      index_reg <= `DGP_GAIN_RESET;
    end else begin
      index_reg <= index_next;
    end
  end

  assign index = index_reg;

endmodule

//--- rtl/dgp_map.vh
// Constants for the digital pin function map: pin counts, source codes,
// pin ranges and widths. Definitions only; included by bare name.
`ifndef DGP_MAP_VH
`define DGP_MAP_VH

// Pin and pair geometry
`define DGP_PINS 16
`define DGP_PAIRS 8
`define DGP_SEL_W 4
`define DGP_SRC_W 3

// Pair source group codes
`define DGP_SRC_NONE 3'h0
`define DGP_SRC_STATUS 3'h1
`define DGP_SRC_DEBUG 3'h2
`define DGP_SRC_OVERLOAD 3'h3
`define DGP_SRC_MANUAL 3'h4
`define DGP_SRC_WAKEUP 3'h5
`define DGP_SRC_REFCLK 3'h6

// Last pair for the low and debug output groups, and the two reference clock pairs
`define DGP_LOW_PAIR_MAX 5
`define DGP_DEBUG_PAIR_MAX 1
`define DGP_REFCLK_PAIR_1 6
`define DGP_REFCLK_PAIR_2 7

// Status mux groups and width
`define DGP_GRP_MAIN 2'h0
`define DGP_GRP_RX 2'h1
`define DGP_GRP_TX 2'h2
`define DGP_GRP_AGC 2'h3
`define DGP_STAT_W 12

// Overload receiver selection
`define DGP_OVL_RX1 2'h1
`define DGP_OVL_RX2 2'h2
`define DGP_OVL_BOTH 2'h3

// Gain index width and reset value
`define DGP_GAIN_W 8
`define DGP_GAIN_RESET 8'hFF

`endif

//--- rtl/dgp_pin_sync.v
// Two-flop synchroniser for pin inputs with rise and fall pulse detect.
// Assumes pins are asynchronous to core_clk; one flop set per bit.
`timescale 1ns/10ps

module dgp_pin_sync #(
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] last_reg;

  ////////////////////////////////////////////////////////////////////////
  // Stage one is read only by stage two; edges come from later stages
  always @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
      last_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One pulse per edge, however long the level is held
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule
